// ---- tss_map.vh ----
// constants for the time-slot switch memory scheduler
`ifndef TSS_MAP_VH
`define TSS_MAP_VH
`define TSS_RCL_LAST 3'h7
`define TSS_RCL_PCM_A 3'h0
`define TSS_RCL_PCM_B 3'h4
`define TSS_RCL_PCM_C 3'h7
`define TSS_RCL_SUB_RD_A 3'h5
`define TSS_RCL_SUB_RD_B 3'h6
`define TSS_RCL_SUB_WR_A 3'h1
`define TSS_RCL_SUB_WR_B 3'h3
`define TSS_MODE_0 2'h0
`define TSS_MODE_1 2'h1
`define TSS_MODE_2 2'h2
`define TSS_CODE_UNASSIGNED 4'h0
`define TSS_CODE_PREPROC 4'h8
`define TSS_SLOT_LAST 5'h1f
`define TSS_FIFO_DEPTH 16
`endif

// ---- tss_fifo.v ----
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module tss_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire clock_i,
  input wire reset_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr = in_valid_i && in_ready_o;
  wire do_rd = out_valid_o && out_ready_i;
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  always @(posedge clock_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always @(posedge clock_i) begin
    if (reset_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ---- tss_cs_detect.v ----
// change detector for upstream control/signalling channels
`timescale 1ns/1ps
module tss_cs_detect #(
  parameter SLOTS = 32,
  parameter SW = 5,
  parameter DW = 8
) (
  // clock and reset
  input wire clock_i,
  input wire reset_i,
  // sample of one upstream slot
  input wire sample_i,
  input wire [SW-1:0] slot_i,
  input wire [DW-1:0] data_i,
  // change report
  output reg change_o,
  output reg [SW-1:0] change_slot_o
);
  // last value per slot; flip-flops indexed by slot
  reg [DW-1:0] last [0:SLOTS-1];
  reg [SLOTS-1:0] seen;
  always @(posedge clock_i) begin
    if (sample_i) begin
      last[slot_i] <= data_i;
    end
  end
  always @(posedge clock_i) begin
    if (reset_i) begin
      seen <= {SLOTS{1'b0}};
      change_o <= 1'b0;
      change_slot_o <= {SW{1'b0}};
    end else begin
      change_o <= 1'b0;
      if (sample_i) begin
        seen[slot_i] <= 1'b1;
        // first sample of a slot after reset only primes the history
        if (seen[slot_i] && last[slot_i] != data_i) begin
          change_o <= 1'b1;
          change_slot_o <= slot_i;
        end
      end
    end
  end
endmodule

// ---- tss_sched.v ----
// data-memory access scheduler with preprocessed channel support
`timescale 1ns/1ps
`include "tss_map.vh"
// Overview of operation
// - downstream pcm writes start after slot 2n, 4n or 8n per pcm mode
// - downstream pcm writes only in reference periods 0, 4 and 7
// - period at start of the pcm write block is not a valid write
// - subscriber downstream data for slots 2n+4 and 2n+5 fetched in odd slot 2n+1, same lead in every subscriber mode
// - subscriber downstream reads happen in reference periods 5 and 6
// - subscriber reads alternate even slot line 0 with odd slots per line
// - upstream subscriber writes begin with line 0 at start of slot 2n
// - subscriber upstream writes happen in reference periods 1 and 3
// - pcm upstream data fetched ahead per pcm mode block size
// - pcm upstream reads happen in reference periods 0, 4 and 7
// - period at start of slot 2n+1, 4n+2, 8n+4 is not valid
// - pcm upstream read lines split in mode 1 only, modes 0 and 2 stay on line 0
// - read after write switches same frame, else previous frame data
// - each subscriber slot can be a preprocessed channel to the cpu
// - monitor handler uses 16-byte fifo, one selected slot at a time
// - control/signalling via control memory, upstream changes raise interrupt
// - control memory reset sets all slots to unassigned code 0000
// - preprocessed channels may be set up during normal operation
// - frame carries 32 slots, b channels in 4k and 4k+1
// - each slot pair configurable per direction
module tss_sched #(
  parameter SLOTS = 32,
  parameter SW = 5,
  parameter DW = 8
) (
  // clock, reset, framing
  input wire clock_i,
  input wire reset_i,
  input wire frame_i,
  input wire ref_tick_i,
  // modes
  input wire [1:0] pcm_mode_i,
  input wire [1:0] sub_mode_i,
  input wire pcm_sync_i,
  // pcm side data
  input wire [DW-1:0] pcm_rx_data_i,
  output reg [DW-1:0] pcm_tx_data_o,
  output reg [1:0] pcm_transmit_line_o,
  output reg pcm_tx_valid_o,
  // subscriber side data
  input wire [DW-1:0] sub_rx_data_i,
  output reg [DW-1:0] sub_tx_data_o,
  output reg [1:0] subscriber_downstream_line_o,
  output reg sub_tx_valid_o,
  output reg [1:0] subscriber_upstream_line_o,
  // control memory access
  input wire cm_reset_i,
  input wire cm_wr_i,
  input wire cm_up_i,
  input wire [SW-1:0] cm_slot_i,
  input wire [3:0] cm_code_i,
  input wire [DW-1:0] cm_data_i,
  output reg [DW-1:0] cm_rd_data_o,
  output reg cm_busy_o,
  // monitor handler
  input wire [SW-1:0] mon_slot_i,
  input wire mon_rd_ready_i,
  output reg [DW-1:0] mon_rd_data_o,
  output reg mon_rd_valid_o,
  output reg mon_full_o,
  // change detection
  output reg cs_change_o,
  output reg [SW-1:0] cs_change_slot_o,
  // state
  output reg [2:0] ref_period_o,
  output reg [SW-1:0] slot_o
);
  // one-frame data memories, downstream and upstream
  reg [DW-1:0] dm_down [0:SLOTS-1];
  reg [DW-1:0] dm_up [0:SLOTS-1];
  reg [3:0] cm_code_dn [0:SLOTS-1];
  reg [3:0] cm_code_upm [0:SLOTS-1];
  reg [DW-1:0] cm_val [0:SLOTS-1];
  reg [2:0] ref_period;
  reg [SW-1:0] slot;
  reg [SW:0] cm_clr;
  reg [2:0] step;
  wire [2:0] next_ref_period = ref_period + 3'h1;
  integer i;
  // block start per pcm mode
  wire pcm_blk_start = (pcm_mode_i == `TSS_MODE_0) ? (slot[0] == 1'b0) :
                       (pcm_mode_i == `TSS_MODE_1) ? (slot[1:0] == 2'h0) :
                       (slot[2:0] == 3'h0);
  wire pcm_up_start = (pcm_mode_i == `TSS_MODE_0) ? (slot[0] == 1'b1) :
                      (pcm_mode_i == `TSS_MODE_1) ? (slot[1:0] == 2'h2) :
                      (slot[2:0] == 3'h4);
  wire pcm_period = (ref_period == `TSS_RCL_PCM_A) || (ref_period == `TSS_RCL_PCM_B) ||
                    (ref_period == `TSS_RCL_PCM_C);
  wire first_period = (ref_period == `TSS_RCL_PCM_A);
  wire pcm_wr_ok = pcm_sync_i && pcm_period && !(pcm_blk_start && first_period);
  wire pcm_rd_ok = pcm_sync_i && pcm_period && !(pcm_up_start && first_period);
  wire sub_rd = (ref_period == `TSS_RCL_SUB_RD_A) || (ref_period == `TSS_RCL_SUB_RD_B);
  wire sub_wr = (ref_period == `TSS_RCL_SUB_WR_A) || (ref_period == `TSS_RCL_SUB_WR_B);
  // subscriber fetch lead per mode: 3, 3 and 3 slots ahead of the odd trigger
  wire [SW-1:0] sub_lead = (sub_mode_i == `TSS_MODE_0) ? 5'h3 :
                           (sub_mode_i == `TSS_MODE_1) ? 5'h3 : 5'h3;
  wire [SW-1:0] sub_rd_slot = slot + sub_lead + {4'h0, ref_period == `TSS_RCL_SUB_RD_B};
  // pcm fetch distance per mode
  wire [SW-1:0] pcm_lead = (pcm_mode_i == `TSS_MODE_0) ? 5'h4 :
                           (pcm_mode_i == `TSS_MODE_1) ? 5'h7 : 5'hd;
  wire [SW-1:0] pcm_rd_slot = slot + pcm_lead;
  wire [SW-1:0] up_wr_slot = {slot[SW-1:1], ref_period == `TSS_RCL_SUB_WR_B};
  // monitor fifo
  wire mon_in_ready;
  wire mon_take = ref_tick_i && sub_wr && (up_wr_slot == mon_slot_i) && !mon_slot_i[0] &&
                  (cm_code_upm[up_wr_slot] != `TSS_CODE_UNASSIGNED);
  wire mon_out_valid;
  wire [DW-1:0] mon_out_data;
  wire cs_sample = ref_tick_i && sub_wr && up_wr_slot[0] &&
                   (cm_code_upm[up_wr_slot] != `TSS_CODE_UNASSIGNED);
  wire cs_chg;
  wire [SW-1:0] cs_slot;
  tss_fifo #(.WIDTH(DW), .DEPTH(`TSS_FIFO_DEPTH), .AW(4)) u_mon_fifo (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_valid_i(mon_take),
    .in_ready_o(mon_in_ready),
    .in_data_i(sub_rx_data_i),
    .out_valid_o(mon_out_valid),
    .out_ready_i(mon_rd_ready_i && !mon_rd_valid_o),
    .out_data_o(mon_out_data)
  );
  tss_cs_detect #(.SLOTS(SLOTS), .SW(SW), .DW(DW)) u_cs (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .sample_i(cs_sample),
    .slot_i(up_wr_slot),
    .data_i(sub_rx_data_i),
    .change_o(cs_chg),
    .change_slot_o(cs_slot)
  );
  // reference period and slot counters
  always @(posedge clock_i) begin
    if (reset_i || frame_i) begin
      ref_period <= 3'h0;
      slot <= {SW{1'b0}};
      step <= 3'h0;
    end else if (ref_tick_i) begin
      ref_period <= next_ref_period;
      if (ref_period == `TSS_RCL_LAST) begin
        slot <= (slot == `TSS_SLOT_LAST) ? {SW{1'b0}} : slot + 5'h1;
        if (slot[0]) begin
          step <= step + 3'h1;
        end
      end
    end
  end
  // data memory ports: pcm owns 0/4/7, subscriber writes 1/3, reads 5/6
  always @(posedge clock_i) begin
    if (ref_tick_i && pcm_wr_ok) begin
      dm_down[slot] <= pcm_rx_data_i;
    end
    if (ref_tick_i && sub_wr && cm_code_upm[up_wr_slot] == `TSS_CODE_UNASSIGNED) begin
      dm_up[up_wr_slot] <= sub_rx_data_i;
    end
  end
  // control memory with reset walk and live writes
  always @(posedge clock_i) begin
    if (cm_clr != {(SW+1){1'b0}}) begin
      cm_code_dn[cm_clr[SW-1:0]] <= `TSS_CODE_UNASSIGNED;
      cm_code_upm[cm_clr[SW-1:0]] <= `TSS_CODE_UNASSIGNED;
      // data field cleared too so a read after the walk is never unknown
      cm_val[cm_clr[SW-1:0]] <= {DW{1'b0}};
    end else if (cm_wr_i) begin
      // code set per slot and direction, data field shared by both directions; ignored during the walk
      if (cm_up_i) begin
        cm_code_upm[cm_slot_i] <= cm_code_i;
      end else begin
        cm_code_dn[cm_slot_i] <= cm_code_i;
      end
      cm_val[cm_slot_i] <= cm_data_i;
    end
  end
  always @(posedge clock_i) begin
    if (reset_i) begin
      cm_clr <= {(SW+1){1'b0}};
      cm_busy_o <= 1'b0;
    end else if (cm_reset_i && cm_clr == {(SW+1){1'b0}}) begin
      cm_clr <= {1'b1, {SW{1'b0}}};
      cm_busy_o <= 1'b1;
    end else if (cm_clr != {(SW+1){1'b0}}) begin
      // walk from slot 0 up; low bits wrap the index
      cm_clr <= (cm_clr[SW-1:0] == `TSS_SLOT_LAST) ? {(SW+1){1'b0}} : cm_clr + 6'h1;
      cm_busy_o <= (cm_clr[SW-1:0] != `TSS_SLOT_LAST);
    end
  end
  // output registers
  always @(posedge clock_i) begin
    if (reset_i) begin
      pcm_tx_data_o <= {DW{1'b0}};
      pcm_transmit_line_o <= 2'h0;
      pcm_tx_valid_o <= 1'b0;
      sub_tx_data_o <= {DW{1'b0}};
      subscriber_downstream_line_o <= 2'h0;
      sub_tx_valid_o <= 1'b0;
      subscriber_upstream_line_o <= 2'h0;
      cm_rd_data_o <= {DW{1'b0}};
      mon_rd_data_o <= {DW{1'b0}};
      mon_rd_valid_o <= 1'b0;
      mon_full_o <= 1'b0;
      cs_change_o <= 1'b0;
      cs_change_slot_o <= {SW{1'b0}};
      ref_period_o <= 3'h0;
      slot_o <= {SW{1'b0}};
    end else begin
      pcm_tx_valid_o <= 1'b0;
      sub_tx_valid_o <= 1'b0;
      ref_period_o <= ref_period;
      slot_o <= slot;
      mon_full_o <= !mon_in_ready;
      cs_change_o <= cs_chg;
      cs_change_slot_o <= cs_slot;
      cm_rd_data_o <= cm_val[cm_slot_i];
      if (mon_rd_valid_o) begin
        mon_rd_valid_o <= 1'b0;
      end else if (mon_out_valid && mon_rd_ready_i) begin
        mon_rd_valid_o <= 1'b1;
        mon_rd_data_o <= mon_out_data;
      end
      if (ref_tick_i && pcm_rd_ok) begin
        // whatever is in memory now: this frame if written already, else last
        pcm_tx_data_o <= dm_up[pcm_rd_slot];
        pcm_tx_valid_o <= 1'b1;
        // mode 1 sends reads in slot 4n+3 to line 2, every other read goes to line 0
        if (pcm_mode_i == `TSS_MODE_2) begin
          pcm_transmit_line_o <= 2'h0;
        end else begin
          pcm_transmit_line_o <= {pcm_up_start ^ slot[pcm_mode_i == `TSS_MODE_0 ? 0 : 1], 1'b0};
        end
      end
      if (ref_tick_i && sub_rd && slot[0]) begin
        if (cm_code_dn[sub_rd_slot] == `TSS_CODE_PREPROC) begin
          sub_tx_data_o <= cm_val[sub_rd_slot];
        end else begin
          sub_tx_data_o <= dm_down[sub_rd_slot];
        end
        sub_tx_valid_o <= 1'b1;
        // even reads go to line 0, odd reads walk lines per mode
        if (ref_period == `TSS_RCL_SUB_RD_A) begin
          subscriber_downstream_line_o <= 2'h0;
        end else if (sub_mode_i == `TSS_MODE_0) begin
          subscriber_downstream_line_o <= step[1:0];
        end else if (sub_mode_i == `TSS_MODE_1) begin
          subscriber_downstream_line_o <= {1'b0, step[0]};
        end else begin
          subscriber_downstream_line_o <= 2'h0;
        end
      end
      if (ref_tick_i && sub_wr) begin
        subscriber_upstream_line_o <= 2'h0;
      end
    end
  end
endmodule

// ---- tss_sched_assertions.sv ----
// concurrent checks on the scheduler top ports
`timescale 1ns/1ps
module tss_sched_assertions (
  // clock and reset
  input wire clock_i,
  input wire reset_i,
  // watched ports
  input wire ref_tick_i,
  input wire pcm_sync_i,
  input wire cm_reset_i,
  input wire [1:0] pcm_mode_i,
  input wire [1:0] sub_mode_i,
  input wire pcm_tx_valid_o,
  input wire [1:0] pcm_transmit_line_o,
  input wire sub_tx_valid_o,
  input wire [1:0] subscriber_downstream_line_o,
  input wire [1:0] subscriber_upstream_line_o,
  input wire cm_busy_o,
  input wire mon_full_o,
  input wire cs_change_o,
  input wire [4:0] cs_change_slot_o,
  input wire [2:0] ref_period_o,
  input wire [4:0] slot_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_pcm_rd_period: assert property (pcm_tx_valid_o |-> ref_period_o inside {3'h0, 3'h4, 3'h7})
    else $error("pcm access outside periods 0 4 7");
  a_pcm_needs_sync: assert property (pcm_tx_valid_o |-> $past(ref_tick_i) && $past(pcm_sync_i))
    else $error("pcm access without tick or sync");
  a_pcm_odd_start: assert property (pcm_tx_valid_o && ref_period_o == 3'h0 && pcm_mode_i == 2'h0 |-> !slot_o[0])
    else $error("pcm access at start of odd slot");
  a_pcm_line_mode: assert property (pcm_tx_valid_o && pcm_mode_i != 2'h0 |-> !pcm_transmit_line_o[0] && (pcm_mode_i == 2'h1 || pcm_transmit_line_o == 2'h0))
    else $error("pcm transmit line wrong for mode");
  a_sub_rd_period: assert property (sub_tx_valid_o |-> ref_period_o inside {3'h5, 3'h6} && $past(ref_tick_i))
    else $error("subscriber read outside periods 5 6");
  a_sub_line_mode: assert property (sub_tx_valid_o && sub_mode_i != 2'h0 |-> subscriber_downstream_line_o <= ((sub_mode_i == 2'h1) ? 2'h1 : 2'h0))
    else $error("downstream line beyond mode");
  a_up_line_zero: assert property (subscriber_upstream_line_o == 2'h0)
    else $error("upstream line not zero");
  a_cm_busy_start: assert property (cm_reset_i && !cm_busy_o |=> cm_busy_o)
    else $error("clear walk did not start");
  a_cm_busy_span: assert property ($rose(cm_busy_o) |-> cm_busy_o [*8] ##[1:40] !cm_busy_o)
    else $error("clear walk length wrong");
  a_period_step: assert property (ref_period_o != $past(ref_period_o) |-> ref_period_o == $past(ref_period_o) + 3'h1 || ref_period_o == 3'h0)
    else $error("reference period skipped");
  a_cs_odd_slot: assert property (cs_change_o |-> cs_change_slot_o[0])
    else $error("change reported on even slot");
  c_pcm: cover property (pcm_tx_valid_o);
  c_sub: cover property (sub_tx_valid_o);
  c_cs: cover property (cs_change_o);
  c_full: cover property (mon_full_o);
endmodule
bind tss_sched tss_sched_assertions i_tss_sched_assertions (.clock_i(clock_i), .reset_i(reset_i),
  .ref_tick_i(ref_tick_i), .pcm_sync_i(pcm_sync_i), .cm_reset_i(cm_reset_i),
  .pcm_mode_i(pcm_mode_i), .sub_mode_i(sub_mode_i), .pcm_tx_valid_o(pcm_tx_valid_o),
  .pcm_transmit_line_o(pcm_transmit_line_o), .sub_tx_valid_o(sub_tx_valid_o),
  .subscriber_downstream_line_o(subscriber_downstream_line_o),
  .subscriber_upstream_line_o(subscriber_upstream_line_o), .cm_busy_o(cm_busy_o),
  .mon_full_o(mon_full_o), .cs_change_o(cs_change_o), .cs_change_slot_o(cs_change_slot_o),
  .ref_period_o(ref_period_o), .slot_o(slot_o));

// ---- tss_partner.sv ----
// pcm highway and subscriber circuit model feeding receive bytes per slot
`timescale 1ns/1ps
module tss_partner (
  // clock and framing
  input wire clock_i,
  input wire reset_i,
  input wire frame_i,
  input wire ref_tick_i,
  // receive bytes
  output logic [7:0] pcm_rx_data_o,
  output logic [7:0] sub_rx_data_o
);
  logic [2:0] per = 3'h0;
  logic [4:0] slot = 5'h00;
  logic [2:0] frm = 3'h0;
  // frame of 32 slots of 8 periods each
  always @(posedge clock_i) begin
    if (reset_i) begin
      per <= 3'h0;
      slot <= 5'h00;
      frm <= 3'h0;
    end else if (frame_i) begin
      per <= 3'h0;
      slot <= 5'h00;
      frm <= frm + 3'h1;
    end else if (ref_tick_i) begin
      per <= per + 3'h1;
      if (per == 3'h7) slot <= slot + 5'h01;
    end
  end
  // bytes change every frame so the change detector always has work
  always @(negedge clock_i) begin
    sub_rx_data_o <= {frm, slot};
    pcm_rx_data_o <= {slot, frm};
  end
endmodule

// ---- test_tss_sched.sv ----
// self-checking bench for the time-slot memory scheduler
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module test_tss_sched;
  logic clock_i = 1'b0, reset_i = 1'b1, frame_i = 1'b0, ref_tick_i = 1'b0, pcm_sync_i = 1'b0;
  logic [1:0] pcm_mode_i = 2'h0, sub_mode_i = 2'h0;
  logic cm_reset_i = 1'b0, cm_wr_i = 1'b0, cm_up_i = 1'b0, mon_rd_ready_i = 1'b0;
  logic [4:0] cm_slot_i = 5'h00, mon_slot_i = 5'h00;
  logic [3:0] cm_code_i = 4'h0;
  logic [7:0] cm_data_i = 8'h00;
  wire [7:0] pcm_rx, sub_rx, pcm_tx_data_o, sub_tx_data_o, cm_rd_data_o, mon_rd_data_o;
  wire [1:0] pcm_transmit_line_o, subscriber_downstream_line_o, subscriber_upstream_line_o;
  wire pcm_tx_valid_o, sub_tx_valid_o, cm_busy_o, mon_rd_valid_o, mon_full_o, cs_change_o;
  wire [4:0] cs_change_slot_o, slot_o;
  wire [2:0] ref_period_o;
  int miscompares = 0, n_tests = 0, n_pcm, n_sub, bad, n_mon, n_cs;
  logic [4:0] last_cs;
  logic [7:0] sub_pp;
  always #2 clock_i = ~clock_i;
  tss_partner i_tss_partner (.clock_i(clock_i), .reset_i(reset_i), .frame_i(frame_i),
    .ref_tick_i(ref_tick_i), .pcm_rx_data_o(pcm_rx), .sub_rx_data_o(sub_rx));
  tss_sched i_tss_sched (.clock_i(clock_i), .reset_i(reset_i), .frame_i(frame_i),
    .ref_tick_i(ref_tick_i), .pcm_mode_i(pcm_mode_i), .sub_mode_i(sub_mode_i),
    .pcm_sync_i(pcm_sync_i), .pcm_rx_data_i(pcm_rx), .pcm_tx_data_o(pcm_tx_data_o),
    .pcm_transmit_line_o(pcm_transmit_line_o), .pcm_tx_valid_o(pcm_tx_valid_o),
    .sub_rx_data_i(sub_rx), .sub_tx_data_o(sub_tx_data_o),
    .subscriber_downstream_line_o(subscriber_downstream_line_o), .sub_tx_valid_o(sub_tx_valid_o),
    .subscriber_upstream_line_o(subscriber_upstream_line_o), .cm_reset_i(cm_reset_i),
    .cm_wr_i(cm_wr_i), .cm_up_i(cm_up_i), .cm_slot_i(cm_slot_i), .cm_code_i(cm_code_i),
    .cm_data_i(cm_data_i), .cm_rd_data_o(cm_rd_data_o), .cm_busy_o(cm_busy_o),
    .mon_slot_i(mon_slot_i), .mon_rd_ready_i(mon_rd_ready_i), .mon_rd_data_o(mon_rd_data_o),
    .mon_rd_valid_o(mon_rd_valid_o), .mon_full_o(mon_full_o), .cs_change_o(cs_change_o),
    .cs_change_slot_o(cs_change_slot_o), .ref_period_o(ref_period_o), .slot_o(slot_o));
  // bench-side watch of every access pulse
  always @(negedge clock_i) begin
    if (sub_tx_valid_o === 1'b1 && slot_o == 5'h01 && ref_period_o == 3'h6) sub_pp = sub_tx_data_o;
    if (pcm_tx_valid_o === 1'b1) begin
      n_pcm++;
      if (!(ref_period_o inside {3'h0, 3'h4, 3'h7})) bad++;
    end
    if (sub_tx_valid_o === 1'b1) begin
      n_sub++;
      if (!(ref_period_o inside {3'h5, 3'h6})) bad++;
    end
    if (mon_rd_valid_o === 1'b1) n_mon++;
    if (cs_change_o === 1'b1) begin
      n_cs++;
      last_cs = cs_change_slot_o;
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic run_frame();
    @(negedge clock_i) frame_i = 1'b1;
    @(negedge clock_i) frame_i = 1'b0;
    ref_tick_i = 1'b1;
    repeat (256) @(negedge clock_i);
    ref_tick_i = 1'b0;
    // let the last access pulse drain before modes change
    repeat (2) @(negedge clock_i);
  endtask
  task automatic cm_write(input logic up, input logic [4:0] sl, input logic [3:0] cd,
                          input logic [7:0] dt);
    @(negedge clock_i) {cm_wr_i, cm_up_i, cm_slot_i, cm_code_i, cm_data_i} = {1'b1, up, sl, cd, dt};
    @(negedge clock_i) cm_wr_i = 1'b0;
  endtask
  task automatic cm_read(input logic up, input logic [4:0] sl, output logic [7:0] dt);
    @(negedge clock_i) {cm_up_i, cm_slot_i} = {up, sl};
    repeat (2) @(negedge clock_i);
    dt = cm_rd_data_o;
  endtask
  // a hang costs a mismatch; the tests take about 7400 cycles
  initial begin
    #160000;
    miscompares++;
    final_report();
  end
  initial begin
    logic [7:0] rd;
    repeat (12) @(negedge clock_i);
    reset_i = 1'b0;
    @(negedge clock_i) cm_reset_i = 1'b1;
    @(negedge clock_i) cm_reset_i = 1'b0;
    cm_write(1'b0, 5'h03, 4'h8, 8'h3c);
    for (int i = 0; i < 100 && cm_busy_o !== 1'b0; i++) @(negedge clock_i);
    `CHK("cm_busy", 1'b0, cm_busy_o)
    cm_read(1'b0, 5'h03, rd);
    `CHK("cleared slot", 8'h00, rd)
    cm_write(1'b0, 5'h05, 4'h8, 8'ha5);
    cm_read(1'b0, 5'h05, rd);
    `CHK("rewritten slot", 8'ha5, rd)
    pcm_sync_i = 1'b1;
    for (int p = 0; p < 3; p++)
      for (int s = 0; s < 3; s++) begin
        pcm_mode_i = p[1:0];
        sub_mode_i = s[1:0];
        {n_pcm, n_sub, bad} = '0;
        run_frame();
        `CHK("pcm reads seen", 1'b1, n_pcm > 0)
        `CHK("sub reads seen", 1'b1, n_sub > 0)
        `CHK("bad periods", 0, bad)
      end
    `CHK("preproc byte", 8'ha5, sub_pp)
    pcm_sync_i = 1'b0;
    n_pcm = 0;
    run_frame();
    `CHK("pcm reads unsynced", 0, n_pcm)
    pcm_sync_i = 1'b1;
    cm_write(1'b1, 5'h03, 4'h8, 8'h00);
    cm_write(1'b1, 5'h02, 4'h8, 8'h00);
    mon_slot_i = 5'h02;
    n_cs = 0;
    repeat (18) run_frame();
    `CHK("changes seen", 1'b1, n_cs > 0)
    `CHK("change slot", 5'h03, last_cs)
    `CHK("monitor full", 1'b1, mon_full_o)
    n_mon = 0;
    @(negedge clock_i) mon_rd_ready_i = 1'b1;
    repeat (40) @(negedge clock_i);
    `CHK("monitor bytes", 16, n_mon)
    `CHK("monitor drained", 1'b0, mon_full_o)
    final_report();
  end
endmodule
